// ==== design/uxb_top.sv ====
// serial port extra-bit and done-flag block with an AXI4-Lite slave
//
// Functional notes
// [R1] With extra bit enabled, transmit extra bit follows control bit 3.
// [R2] With parity enabled, control bit 3 has no effect on the frame.
// [R3] With extra bit enabled, received extra bit is stored in bit 2.
// [R4] With extra bit disabled, bit 2 stores the first stop bit level.
// [R5] Software ignores bit 2 while parity is enabled.
// [R6] Transmit-done flag bit 1 sets when the stop bit begins.
// [R7] Transmit-done setting requests the port interrupt when enabled.
// [R8] Only software clears transmit-done; hardware never clears it.
// [R9] Receive-done flag sets when a complete byte has been received.
// [R10] Receive-done also interrupts when enabled; stays until written zero.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module uxb_top (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // axi4-lite write address channel
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  // axi4-lite write data channel
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  // axi4-lite write response channel
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // axi4-lite read address channel
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  // axi4-lite read data channel
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // serial shift engine, same clock
  input  wire logic        i_tx_stop_start,
  input  wire logic        i_rx_byte_done,
  input  wire logic        i_rx_extra_bit,
  input  wire logic        i_rx_stop_bit,
  output logic             o_tx_extra_bit,
  output logic             o_tx_extra_en,
  // interrupt request, level
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // address decode, shared by the read and write paths
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr);
    case (addr)
      uxb_pkg::SERIAL_CTRL_OFS: addr_hit = 1'b1;
      uxb_pkg::PORT_CFG_OFS:    addr_hit = 1'b1;
      uxb_pkg::INT_STATUS_OFS:  addr_hit = 1'b1;
      uxb_pkg::INT_MASK_OFS:    addr_hit = 1'b1;
      default:                  addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  uxb_if fl ();

  logic        aw_have_q;
  logic        aw_have_d;
  logic [7:0]  aw_addr_q;
  logic [7:0]  aw_addr_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [3:0]  w_data_q;
  logic [3:0]  w_data_d;
  logic        w_strb_q;
  logic        w_strb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        arready_q;
  logic        arready_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [2:0]  cfg_q;
  logic [2:0]  cfg_d;
  logic [1:0]  mask_q;
  logic [1:0]  mask_d;
  logic        irq_q;
  logic        irq_d;
  logic        txb_q;
  logic        txb_d;
  logic        txen_q;
  logic        txen_d;
  logic        do_write;
  logic        wr_ok;
  logic        wr_sel_ctrl;
  logic        wr_sel_cfg;
  logic        wr_sel_istat;
  logic        wr_sel_mask;

  // ----------------------------------------------------------------
  // write decode: fires once both address and data are held
  // ----------------------------------------------------------------
  always_comb begin
    do_write     = aw_have_q && w_have_q && !bvalid_q;
    wr_ok        = do_write && w_strb_q;
    wr_sel_ctrl  = wr_ok && (aw_addr_q == uxb_pkg::SERIAL_CTRL_OFS);
    wr_sel_cfg   = wr_ok && (aw_addr_q == uxb_pkg::PORT_CFG_OFS);
    wr_sel_istat = wr_ok && (aw_addr_q == uxb_pkg::INT_STATUS_OFS);
    wr_sel_mask  = wr_ok && (aw_addr_q == uxb_pkg::INT_MASK_OFS);
  end

  // ----------------------------------------------------------------
  // write channels: address and data taken in either order
  // ----------------------------------------------------------------
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (!aw_have_q && i_s_axi_awvalid) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_s_axi_awaddr;
    end
    if (!w_have_q && i_s_axi_wvalid) begin
      w_have_d = 1'b1;
      w_data_d = i_s_axi_wdata[3:0];
      w_strb_d = i_s_axi_wstrb[0];  // all fields sit in byte lane 0
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_hit(aw_addr_q) ? uxb_pkg::RESP_OKAY : uxb_pkg::RESP_SLVERR;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // ready flags mirror the hold flags, kept in their own flops
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
  end

  // ----------------------------------------------------------------
  // write channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 4'h0;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= uxb_pkg::RESP_OKAY;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
    end
  end

  // ----------------------------------------------------------------
  // read channel: one read outstanding, data from a register
  // ----------------------------------------------------------------
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arready_q && i_s_axi_arvalid) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = 32'h0000_0000;
      rresp_d   = addr_hit(i_s_axi_araddr) ? uxb_pkg::RESP_OKAY : uxb_pkg::RESP_SLVERR;
      case (i_s_axi_araddr)
        uxb_pkg::SERIAL_CTRL_OFS: rdata_d[3:0] = fl.ctrl_bits;
        uxb_pkg::PORT_CFG_OFS:    rdata_d[2:0] = cfg_q;
        uxb_pkg::INT_STATUS_OFS:  rdata_d[1:0] = fl.istat;
        uxb_pkg::INT_MASK_OFS:    rdata_d[1:0] = mask_q;
        default:                  rdata_d      = 32'h0000_0000;
      endcase
    end
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= uxb_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // configuration, mask, interrupt and transmit extra bit
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d  = wr_sel_cfg  ? w_data_q[2:0] : cfg_q;
    mask_d = wr_sel_mask ? w_data_q[1:0] : mask_q;
    // port interrupt enable gates the unmasked sticky events
    irq_d  = cfg_q[uxb_pkg::CFG_INTEN_POS] && |(fl.istat & mask_q);  // [R7] [R10]
    // extra bit only used when enabled and parity is off
    txen_d = cfg_q[uxb_pkg::CFG_XBE_POS] && !cfg_q[uxb_pkg::CFG_PARITY_POS];  // [R2]
    txb_d  = txen_d && fl.ctrl_bits[uxb_pkg::EXTRA_TX_BIT_POS];  // [R1]
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cfg_q  <= uxb_pkg::PORT_CFG_RST;
      mask_q <= uxb_pkg::INT_MASK_RST;
      irq_q  <= 1'b0;
      txb_q  <= 1'b0;
      txen_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
      txb_q  <= txb_d;
      txen_q <= txen_d;
    end
  end

  // ----------------------------------------------------------------
  // flag core hookup
  // ----------------------------------------------------------------
  assign fl.tx_stop_start = i_tx_stop_start;
  assign fl.rx_byte_done  = i_rx_byte_done;
  assign fl.rx_extra_val  = i_rx_extra_bit;
  assign fl.rx_stop_val   = i_rx_stop_bit;
  assign fl.xbe           = cfg_q[uxb_pkg::CFG_XBE_POS];
  assign fl.wr_ctrl       = wr_sel_ctrl;
  assign fl.wr_istat      = wr_sel_istat;
  assign fl.wdata         = w_data_q;

  uxb_flags u_flags (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .bus       (fl.core)
  );

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_tx_extra_bit  = txb_q;
  assign o_tx_extra_en   = txen_q;
  assign o_irq           = irq_q;

endmodule : uxb_top

// ==== include/uxb_pkg.sv ====
// shared constants for the serial extra-bit and flag block
package uxb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SERIAL_CTRL_OFS = 8'h00;
  localparam logic [7:0] PORT_CFG_OFS    = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS  = 8'h08;
  localparam logic [7:0] INT_MASK_OFS    = 8'h0C;

  // ----------------------------------------------------------------
  // serial control/status field positions
  // ----------------------------------------------------------------
  localparam int EXTRA_TX_BIT_POS = 3;
  localparam int EXTRA_RX_BIT_POS = 2;
  localparam int TX_DONE_POS      = 1;
  localparam int RX_DONE_POS      = 0;

  // ----------------------------------------------------------------
  // port configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_XBE_POS    = 0;
  localparam int CFG_PARITY_POS = 1;
  localparam int CFG_INTEN_POS  = 2;

  // ----------------------------------------------------------------
  // interrupt status and mask field positions
  // ----------------------------------------------------------------
  localparam int IRQ_RX_POS = 0;
  localparam int IRQ_TX_POS = 1;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] SERIAL_CTRL_RST = 4'h0;
  localparam logic [2:0] PORT_CFG_RST    = 3'h0;
  localparam logic [1:0] INT_STATUS_RST  = 2'h0;
  localparam logic [1:0] INT_MASK_RST    = 2'h0;

  // ----------------------------------------------------------------
  // bus response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : uxb_pkg

// ==== include/uxb_if.sv ====
// carrier between the bus front end and the flag core
`timescale 1ns/1ps
interface uxb_if;
  logic       tx_stop_start;  // stop bit begins on the line
  logic       rx_byte_done;   // complete byte received
  logic       rx_extra_val;   // received extra bit level
  logic       rx_stop_val;    // first stop bit level
  logic       xbe;            // extra_bit_enable
  logic       wr_ctrl;        // write strobe, serial control
  logic       wr_istat;       // write strobe, interrupt status
  logic [3:0] wdata;          // low write data nibble
  logic [3:0] ctrl_bits;      // serial control/status image
  logic [1:0] istat;          // sticky interrupt status

  modport front (
    output tx_stop_start, rx_byte_done, rx_extra_val, rx_stop_val,
    output xbe, wr_ctrl, wr_istat, wdata,
    input  ctrl_bits, istat
  );

  modport core (
    input  tx_stop_start, rx_byte_done, rx_extra_val, rx_stop_val,
    input  xbe, wr_ctrl, wr_istat, wdata,
    output ctrl_bits, istat
  );
endinterface : uxb_if

// ==== design/uxb_flags.sv ====
// flag core: extra bits, done flags and sticky interrupt status
`timescale 1ns/1ps
module uxb_flags (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  uxb_if.core       bus
);

  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [1:0] istat_q;
  logic [1:0] istat_d;

  // ----------------------------------------------------------------
  // next state of control/status bits and interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    istat_d = istat_q;
    // software side: extra_tx_bit is plain storage, flags clear on 0
    if (bus.wr_ctrl) begin
      ctrl_d[uxb_pkg::EXTRA_TX_BIT_POS] = bus.wdata[uxb_pkg::EXTRA_TX_BIT_POS];
      if (!bus.wdata[uxb_pkg::TX_DONE_POS]) begin
        ctrl_d[uxb_pkg::TX_DONE_POS] = 1'b0;  // [R8]
      end
      if (!bus.wdata[uxb_pkg::RX_DONE_POS]) begin
        ctrl_d[uxb_pkg::RX_DONE_POS] = 1'b0;  // [R10]
      end
    end
    // interrupt status clears by writing one
    if (bus.wr_istat) begin
      istat_d = istat_q & ~bus.wdata[1:0];
    end
    // hardware events come last so a set beats a same-cycle clear
    if (bus.tx_stop_start) begin
      ctrl_d[uxb_pkg::TX_DONE_POS]  = 1'b1;  // [R6]
      istat_d[uxb_pkg::IRQ_TX_POS]  = 1'b1;  // [R7]
    end
    if (bus.rx_byte_done) begin
      ctrl_d[uxb_pkg::RX_DONE_POS]  = 1'b1;  // [R9]
      istat_d[uxb_pkg::IRQ_RX_POS]  = 1'b1;  // [R10]
      if (bus.xbe) begin
        ctrl_d[uxb_pkg::EXTRA_RX_BIT_POS] = bus.rx_extra_val;  // [R3]
      end else begin
        ctrl_d[uxb_pkg::EXTRA_RX_BIT_POS] = bus.rx_stop_val;   // [R4]
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_q  <= uxb_pkg::SERIAL_CTRL_RST;
      istat_q <= uxb_pkg::INT_STATUS_RST;
    end else begin
      ctrl_q  <= ctrl_d;
      istat_q <= istat_d;
    end
  end

  assign bus.ctrl_bits = ctrl_q;
  assign bus.istat     = istat_q;

endmodule : uxb_flags

// ==== tb/uxb_chk.sv ====
// concurrent checks on the ports of the serial extra-bit block
`timescale 1ns/1ps
module uxb_chk (
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic        i_tx_stop_start,
  input wire logic        i_rx_byte_done,
  input wire logic        o_tx_extra_bit,
  input wire logic        o_tx_extra_en,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------
  // bus steps
  // ---------------------------------------------------------------
  sequence s_wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready && !o_s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  a_write_lat: assert property (s_wr_take |-> ##2 o_s_axi_bvalid)
    else $error("write response late");
  a_read_lat: assert property (s_rd_take |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read answer late");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
  // ---------------------------------------------------------------
  // extra bit and interrupt
  // ---------------------------------------------------------------
  a_tx_bit_off: assert property (!o_tx_extra_en |-> !o_tx_extra_bit)
    else $error("extra bit driven while unused");
  a_tx_bit_cause: assert property ($changed(o_tx_extra_bit) |-> $past(o_s_axi_bvalid, 1))
    else $error("extra bit moved without a write");
  a_irq_rise: assert property ($rose(o_irq) |-> $past(i_tx_stop_start, 2) ||
    $past(i_rx_byte_done, 2) || $past(o_s_axi_bvalid, 1)) else $error("irq without cause");
  a_irq_fall: assert property ($fell(o_irq) |-> $past(o_s_axi_bvalid, 1))
    else $error("irq cleared by hardware");
endmodule : uxb_chk

// ==== tb/uxb_serial_model.sv ====
// behavioural serial shift engine raising the event pulses
`timescale 1ns/1ps
module uxb_serial_model (
  input  wire logic i_clock,
  output logic      o_tx_stop_start,
  output logic      o_rx_byte_done,
  output logic      o_rx_extra_bit,
  output logic      o_rx_stop_bit
);
  logic go_tx = 1'h0;
  logic go_rx = 1'h0;
  logic ex_v  = 1'h0;
  logic st_v  = 1'h0;
  initial begin
    o_tx_stop_start = 1'h0;
    o_rx_byte_done  = 1'h0;
    o_rx_extra_bit  = 1'h0;
    o_rx_stop_bit   = 1'h0;
  end
  // one-cycle pulses; bit levels toggle whenever they are not valid
  always @(posedge i_clock) begin
    o_tx_stop_start <= go_tx;
    o_rx_byte_done  <= go_rx;
    o_rx_extra_bit  <= go_rx ? ex_v : ~o_rx_extra_bit;
    o_rx_stop_bit   <= go_rx ? st_v : ~o_rx_stop_bit;
    go_tx = 1'h0;
    go_rx = 1'h0;
  end
  task automatic send_tx;
    @(negedge i_clock);
    go_tx = 1'h1;
    @(posedge i_clock);
  endtask : send_tx
  task automatic send_rx(input logic ex, input logic st);
    @(negedge i_clock);
    ex_v = ex;
    st_v = st;
    go_rx = 1'h1;
    @(posedge i_clock);
  endtask : send_rx
endmodule : uxb_serial_model

// ==== tb/uxb_top_tb.sv ====
// self-checking bench for the serial extra-bit block
`timescale 1ns/1ps
module uxb_top_tb;
  logic        i_clock = 1'h0;
  logic        i_sys_rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic [3:0]  strb_v = 4'hf;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_bit, tx_en;
  logic        tx_ss, rx_bd, rx_ex, rx_st;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd_v;
  logic [31:0] rnd = 32'h0000_0055;
  int          num_errors = 0;
  int          n_checks = 0;

  always #5 i_clock = ~i_clock;

  uxb_top uxb_top_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_tx_stop_start(tx_ss),
    .i_rx_byte_done(rx_bd), .i_rx_extra_bit(rx_ex), .i_rx_stop_bit(rx_st),
    .o_tx_extra_bit(tx_bit), .o_tx_extra_en(tx_en), .o_irq(irq));
  uxb_serial_model uxb_serial_model_i (.i_clock(i_clock), .o_tx_stop_start(tx_ss),
    .o_rx_byte_done(rx_bd), .o_rx_extra_bit(rx_ex), .o_rx_stop_bit(rx_st));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic exp_en(input logic xbe, input logic par);
    return xbe & ~par;
  endfunction : exp_en
  function automatic logic exp_rx(input logic xbe, input logic ex, input logic st);
    return xbe ? ex : st;
  endfunction : exp_rx
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic settle;
    repeat (3) @(posedge i_clock);
    #1;
  endtask : settle
  // write: offer address and data together, release each when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    ad = 1'h0;
    wd = 1'h0;
    while (!(ad && wd)) begin
      @(posedge i_clock);
      if (!ad && awready === 1'h1) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wd && wready === 1'h1) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge i_clock); while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge i_clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge i_clock); while (rvalid !== 1'h1);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : axr

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      axr(8'(4 * k));
      chk(rd_v, 32'h0000_0000);
      chk(resp, (k == 4) ? uxb_pkg::RESP_SLVERR : uxb_pkg::RESP_OKAY);
    end
    axw(8'h10, 32'h0000_000f);
    chk(resp, uxb_pkg::RESP_SLVERR);
    // a write with byte lane 0 off changes nothing and answers okay
    strb_v = 4'h0;
    axw(uxb_pkg::PORT_CFG_OFS, 32'h0000_0007);
    strb_v = 4'hf;
    chk(resp, uxb_pkg::RESP_OKAY);
    axr(uxb_pkg::PORT_CFG_OFS);
    chk(rd_v, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      axw(uxb_pkg::PORT_CFG_OFS, {30'h0, k[1], k[0]});
      axw(uxb_pkg::SERIAL_CTRL_OFS, {28'h0, k[2], 3'h3});
      settle;
      chk(tx_en, exp_en(k[0], k[1]));
      chk(tx_bit, exp_en(k[0], k[1]) & k[2]);
    end
    repeat (12) begin
      rnd = xs(rnd);
      axw(uxb_pkg::PORT_CFG_OFS, {30'h0, rnd[3], rnd[0]});
      uxb_serial_model_i.send_rx(rnd[1], rnd[2]);
      axr(uxb_pkg::SERIAL_CTRL_OFS);
      chk(rd_v[0], 32'h0000_0001);
      // captured bit is skipped while parity is on
      if (!rnd[3]) chk(rd_v[2], exp_rx(rnd[0], rnd[1], rnd[2]));
      axw(uxb_pkg::SERIAL_CTRL_OFS, 32'h0000_0002);
      axr(uxb_pkg::SERIAL_CTRL_OFS);
      chk(rd_v[0], 32'h0000_0000);
    end
    axw(uxb_pkg::PORT_CFG_OFS, 32'h0000_0004);
    axw(uxb_pkg::INT_MASK_OFS, 32'h0000_0003);
    axw(uxb_pkg::INT_STATUS_OFS, 32'h0000_0003);
    settle;
    chk(irq, 32'h0000_0000);
    uxb_serial_model_i.send_tx;
    settle;
    chk(irq, 32'h0000_0001);
    repeat (20) @(posedge i_clock);
    axr(uxb_pkg::SERIAL_CTRL_OFS);
    chk(rd_v[1], 32'h0000_0001);
    // software clears the transmit flag itself
    axw(uxb_pkg::SERIAL_CTRL_OFS, 32'h0000_0001);
    axr(uxb_pkg::SERIAL_CTRL_OFS);
    chk(rd_v[1], 32'h0000_0000);
    axw(uxb_pkg::INT_STATUS_OFS, 32'h0000_0002);
    settle;
    chk(irq, 32'h0000_0000);
    // a flag set and a software clear on one edge: the set wins
    fork
      axw(uxb_pkg::SERIAL_CTRL_OFS, 32'h0000_0001);
      begin
        @(posedge i_clock);
        uxb_serial_model_i.send_tx;
      end
    join
    axr(uxb_pkg::SERIAL_CTRL_OFS);
    chk(rd_v[1], 32'h0000_0001);
    axw(uxb_pkg::INT_MASK_OFS, 32'h0000_0001);
    uxb_serial_model_i.send_tx;
    settle;
    chk(irq, 32'h0000_0000);
    uxb_serial_model_i.send_rx(1'h0, 1'h1);
    settle;
    chk(irq, 32'h0000_0001);
    axw(uxb_pkg::INT_STATUS_OFS, 32'h0000_0003);
    axw(uxb_pkg::PORT_CFG_OFS, 32'h0000_0000);
    uxb_serial_model_i.send_rx(1'h1, 1'h0);
    settle;
    chk(irq, 32'h0000_0000);
    report_and_stop;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    report_and_stop;
  end
endmodule : uxb_top_tb

bind uxb_top uxb_chk uxb_chk_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .i_tx_stop_start(i_tx_stop_start), .i_rx_byte_done(i_rx_byte_done),
  .o_tx_extra_bit(o_tx_extra_bit), .o_tx_extra_en(o_tx_extra_en), .o_irq(o_irq));
